// *** hw/tcc_pkg.sv ***
package tcc_pkg;
  // ==========================================================
  // register word offsets (byte address = 4 * offset)
  localparam logic [3:0] OFS_CNT_LO  = 4'h0;
  localparam logic [3:0] OFS_CNT_HI  = 4'h1;
  localparam logic [3:0] OFS_CAP_LO  = 4'h2;
  localparam logic [3:0] OFS_CAP_HI  = 4'h3;
  localparam logic [3:0] OFS_CMPA_LO = 4'h4;
  localparam logic [3:0] OFS_CMPA_HI = 4'h5;
  localparam logic [3:0] OFS_CTRL_A  = 4'h6;
  localparam logic [3:0] OFS_CTRL_B  = 4'h7;
  localparam logic [3:0] OFS_FLAGS   = 4'h8;
  localparam logic [3:0] OFS_INT_EN  = 4'h9;
  localparam logic [3:0] OFS_CMP_CS  = 4'ha;
  // ==========================================================
  // field positions
  localparam int B_MODE_LO = 0;
  localparam int B_CLK_SEL = 0;
  localparam int B_MODE_HI = 3;
  localparam int B_EDGE    = 6;
  localparam int B_FILT    = 7;
  localparam int B_OVF     = 0;
  localparam int B_CAP     = 5;
  localparam int B_CMP_SEL = 2;
  localparam logic [7:0] CTRL_B_MASK = 8'hdf;
  // ==========================================================
  // reset values and count limits
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] BOTTOM   = 16'h0000;
  localparam logic [15:0] MAX_CNT  = 16'hffff;
  localparam logic [15:0] TOP_8B   = 16'h00ff;
  localparam logic [15:0] TOP_9B   = 16'h01ff;
  localparam logic [15:0] TOP_10B  = 16'h03ff;
  localparam int          PS_W     = 10;
  localparam int          FILT_LEN = 4;
  typedef enum logic {DIR_UP, DIR_DOWN} tcc_dir_type;
endpackage : tcc_pkg

// *** hw/tcc_cap_if.sv ***
`timescale 1ns/1ps
interface tcc_cap_if;
  logic cap_en;
  logic filt_en;
  logic rise_sel;
  logic src_sel;
  logic capture;
  modport ctrl (output cap_en, output filt_en, output rise_sel, output src_sel, input capture);
  modport unit (input cap_en, input filt_en, input rise_sel, input src_sel, output capture);
endinterface : tcc_cap_if

// *** hw/tcc_capture_unit.sv ***
`timescale 1ns/1ps
module tcc_capture_unit
  import tcc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic capture_pin,
  input  wire logic comparator_output,
  tcc_cap_if.unit   cif
);
  typedef struct packed {
    logic [1:0]          pin_s;
    logic [1:0]          cmp_s;
    logic [FILT_LEN-1:0] hist;
    logic                filt;
    logic                prev;
    logic                strobe;
  } tcc_cu_type;

  tcc_cu_type r_reg;
  tcc_cu_type r_next;
  logic       src;
  logic       lvl;

  // ==========================================================
  // sync, filter, edge detect
  always_comb
  begin
    r_next       = r_reg;
    r_next.pin_s = {r_reg.pin_s[0], capture_pin};
    r_next.cmp_s = {r_reg.cmp_s[0], comparator_output};
    src          = cif.src_sel ? r_reg.cmp_s[1] : r_reg.pin_s[1];
    r_next.hist  = {r_reg.hist[FILT_LEN-2:0], src};
    if (&r_reg.hist)
      r_next.filt = 1'b1;
    else if (~|r_reg.hist)
      r_next.filt = 1'b0;
    // unfiltered taps hist[0]; filtered lags it by exactly four cycles
    lvl           = cif.filt_en ? r_reg.filt : r_reg.hist[0];
    r_next.prev   = lvl;
    // prev keeps tracking while disabled so re-enable makes no false edge
    r_next.strobe = cif.cap_en & (lvl != r_reg.prev) & (lvl == cif.rise_sel);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign cif.capture = r_reg.strobe;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_FILT_AGREE: assert property ($changed(r_reg.filt) |-> $past(r_reg.hist) == {FILT_LEN{r_reg.filt}})
    else $error("filter output changed without four agreeing samples");
  AST_FILT_DELAY: assert property ($rose(r_reg.filt) |-> $past(r_reg.hist[0], 4))
    else $error("filter rose without input four cycles earlier");
  AST_CAP_GATED: assert property (!cif.cap_en |=> !r_reg.strobe)
    else $error("capture while capture input disabled");
  CV_FILT_CAP: cover property (cif.filt_en && r_reg.strobe);
endmodule : tcc_capture_unit

// *** hw/tcc_timer.sv ***
`timescale 1ns/1ps
// How it works
// - Clock select zero gives no tick; the count holds.
// - Each tick the count increments, decrements or clears; direction picks up or down.
// - Flags show count at sequence top and count at zero.
// - Upper writes and count/capture upper reads hit the latch; count/capture lower read loads it, lower write commits it.
// - A software count write beats any tick clear or step in that cycle.
// - Count is readable and writable whether or not ticks run.
// - Four-bit mode field over control A and B selects the counting sequence.
// - Overflow flag sets where the mode says and can request an interrupt.
// - An accepted trigger edge copies the whole count into the capture register.
// - Capture flag sets in the very cycle the capture register loads.
// - Capture flag with enable requests interrupt; service or write-one clears it.
// - Capture lower read loads the latch; upper read then returns the latch.
// - Capture register is writable only in modes using it as top, upper first.
// - Comparator select bit switches trigger from capture pin to comparator output.
// - Filter output changes only after four equal consecutive samples.
// - Filter adds exactly four system cycles from input to capture.
// - Filter enable sits in control B and runs on the system clock.
// - Capture input is live except in modes using the capture register as top.
// - A new capture overwrites the capture register; no overrun guard.
// - Capture pin is watched whoever drives it.
// - Bottom is zero; top is 0xffff, fixed 8/9/10-bit, compare A or capture.
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_tick_pin,
  input  wire logic        capture_pin,
  input  wire logic        comparator_output,
  input  wire logic        cap_irq_ack,
  input  wire logic        ovf_irq_ack,
  output logic             cap_irq,
  output logic             ovf_irq,
  output logic             count_top,
  output logic             count_bottom
);
  typedef struct packed {
    logic [15:0]     count;
    logic [7:0]      temp;
    logic [15:0]     capture;
    logic [15:0]     cmpa;
    logic [1:0]      mode_lo;
    logic [7:0]      ctrl_b;
    logic            cmp_sel;
    logic            ovf_flag;
    logic            cap_flag;
    logic            ovf_ie;
    logic            cap_ie;
    tcc_dir_type     dir;
    logic [PS_W-1:0] presc;
    logic [1:0]      ext_s;
    logic            ext_prev;
    logic [7:0]      rd_hi;
    logic [31:0]     rdata;
    logic            waitreq;
    logic            top;
    logic            bottom;
    logic            cap_irq;
    logic            ovf_irq;
  } tcc_core_type;

  tcc_core_type r_reg;
  tcc_core_type r_next;
  tcc_cap_if    cif ();

  logic [3:0]  mode;
  logic [15:0] top_val;
  logic        dual;
  logic        fast;
  logic        icr_top;
  logic        tick;
  logic        ovf_evt;
  logic        wr;
  logic        rd;
  logic [7:0]  wd;
  logic [7:0]  rbyte;

  // ==========================================================
  // mode decode
  always_comb
  begin
    mode    = {r_reg.ctrl_b[B_MODE_HI+1:B_MODE_HI], r_reg.mode_lo};
    dual    = 1'b0;
    fast    = 1'b0;
    icr_top = 1'b0;
    unique case (mode)
      4'h1, 4'h5: top_val = TOP_8B;
      4'h2, 4'h6: top_val = TOP_9B;
      4'h3, 4'h7: top_val = TOP_10B;
      4'h4, 4'h9, 4'hb, 4'hf: top_val = r_reg.cmpa;
      4'h8, 4'ha, 4'hc, 4'he: top_val = r_reg.capture;
      default: top_val = MAX_CNT;
    endcase
    unique case (mode)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: dual = 1'b1;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: fast = 1'b1;
      default: dual = 1'b0;
    endcase
    unique case (mode)
      4'h8, 4'ha, 4'hc, 4'he: icr_top = 1'b1;
      default: icr_top = 1'b0;
    endcase
  end

  // ==========================================================
  // tick select
  always_comb
  begin
    unique case (r_reg.ctrl_b[B_CLK_SEL+2:B_CLK_SEL])
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = &r_reg.presc[2:0];
      3'h3: tick = &r_reg.presc[5:0];
      3'h4: tick = &r_reg.presc[7:0];
      3'h5: tick = &r_reg.presc[9:0];
      3'h6: tick = r_reg.ext_prev & ~r_reg.ext_s[1];
      3'h7: tick = ~r_reg.ext_prev & r_reg.ext_s[1];
    endcase
  end

  // ==========================================================
  // main next-state
  always_comb
  begin
    r_next         = r_reg;
    ovf_evt        = 1'b0;
    wd             = avs_writedata[7:0];
    // access takes effect only at the edge where waitrequest is low
    wr             = avs_write & ~r_reg.waitreq & avs_byteenable[0];
    rd             = avs_read & ~r_reg.waitreq;
    r_next.waitreq = ~((avs_read | avs_write) & r_reg.waitreq);
    r_next.ext_s   = {r_reg.ext_s[0], ext_tick_pin};
    r_next.ext_prev = r_reg.ext_s[1];
    if (r_reg.ctrl_b[B_CLK_SEL+2:B_CLK_SEL] == 3'h0)
      r_next.presc = '0;
    else
      r_next.presc = PS_W'(r_reg.presc + 1'b1);

    // counter: software write first, tick only otherwise
    if (wr && avs_address == OFS_CNT_LO)
      r_next.count = {r_reg.temp, wd};
    else if (tick)
    begin
      if (dual)
      begin
        if (r_reg.dir == DIR_UP)
        begin
          if (r_reg.count >= top_val)
          begin
            r_next.dir   = DIR_DOWN;
            r_next.count = 16'(r_reg.count - 1'b1);
          end
          else
            r_next.count = 16'(r_reg.count + 1'b1);
        end
        else if (r_reg.count == BOTTOM)
        begin
          r_next.dir   = DIR_UP;
          r_next.count = 16'(r_reg.count + 1'b1);
          ovf_evt      = 1'b1;
        end
        else
          r_next.count = 16'(r_reg.count - 1'b1);
      end
      else if (r_reg.count >= top_val)
      begin
        r_next.count = BOTTOM;
        r_next.dir   = DIR_UP;
        ovf_evt      = fast | (r_reg.count == MAX_CNT);
      end
      else
        r_next.count = 16'(r_reg.count + 1'b1);
    end

    // capture register: events overwrite unconditionally
    if (cif.capture)
      r_next.capture = r_reg.count;
    else if (wr && avs_address == OFS_CAP_LO && icr_top)
      r_next.capture = {r_reg.temp, wd};

    // shared high latch
    if (wr && (avs_address == OFS_CNT_HI || avs_address == OFS_CAP_HI || avs_address == OFS_CMPA_HI))
      r_next.temp = wd;
    if (rd && (avs_address == OFS_CNT_LO || avs_address == OFS_CAP_LO))
      r_next.temp = r_reg.rd_hi;
    if (wr && avs_address == OFS_CMPA_LO)
      r_next.cmpa = {r_reg.temp, wd};

    if (wr && avs_address == OFS_CTRL_A)
      r_next.mode_lo = wd[B_MODE_LO+1:B_MODE_LO];
    if (wr && avs_address == OFS_CTRL_B)
      r_next.ctrl_b = wd & CTRL_B_MASK;
    if (wr && avs_address == OFS_INT_EN)
    begin
      r_next.ovf_ie = wd[B_OVF];
      r_next.cap_ie = wd[B_CAP];
    end
    if (wr && avs_address == OFS_CMP_CS)
      r_next.cmp_sel = wd[B_CMP_SEL];

    // flags: clears first so a same-cycle event wins
    if (wr && avs_address == OFS_FLAGS && wd[B_CAP])
      r_next.cap_flag = 1'b0;
    if (wr && avs_address == OFS_FLAGS && wd[B_OVF])
      r_next.ovf_flag = 1'b0;
    if (cap_irq_ack)
      r_next.cap_flag = 1'b0;
    if (ovf_irq_ack)
      r_next.ovf_flag = 1'b0;
    if (cif.capture)
      r_next.cap_flag = 1'b1;
    if (ovf_evt)
      r_next.ovf_flag = 1'b1;

    r_next.cap_irq = r_next.cap_flag & r_next.cap_ie;
    r_next.ovf_irq = r_next.ovf_flag & r_next.ovf_ie;
    r_next.top     = (r_next.count == top_val);
    r_next.bottom  = (r_next.count == BOTTOM);

    // read data and latch snapshot are taken together in the wait cycle
    // gated by a request so read data stand until the next access
    unique case (avs_address)
      OFS_CNT_LO:  rbyte = r_reg.count[7:0];
      OFS_CNT_HI:  rbyte = r_reg.temp;
      OFS_CAP_LO:  rbyte = r_reg.capture[7:0];
      OFS_CAP_HI:  rbyte = r_reg.temp;
      OFS_CMPA_LO: rbyte = r_reg.cmpa[7:0];
      OFS_CMPA_HI: rbyte = r_reg.cmpa[15:8];
      OFS_CTRL_A:  rbyte = {6'h00, r_reg.mode_lo};
      OFS_CTRL_B:  rbyte = r_reg.ctrl_b;
      OFS_FLAGS:   rbyte = {2'h0, r_reg.cap_flag, 4'h0, r_reg.ovf_flag};
      OFS_INT_EN:  rbyte = {2'h0, r_reg.cap_ie, 4'h0, r_reg.ovf_ie};
      OFS_CMP_CS:  rbyte = {5'h00, r_reg.cmp_sel, 2'h0};
      default:     rbyte = RST_BYTE;
    endcase
    if (r_reg.waitreq && (avs_read || avs_write))
    begin
      r_next.rdata = {24'h000000, rbyte};
      r_next.rd_hi = (avs_address == OFS_CAP_LO) ? r_reg.capture[15:8] : r_reg.count[15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg         <= '0;
      r_reg.waitreq <= 1'b1;
      r_reg.bottom  <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign cif.cap_en   = ~icr_top;
  assign cif.filt_en  = r_reg.ctrl_b[B_FILT];
  assign cif.rise_sel = r_reg.ctrl_b[B_EDGE];
  assign cif.src_sel  = r_reg.cmp_sel;

  tcc_capture_unit u_cap (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .capture_pin       (capture_pin),
    .comparator_output (comparator_output),
    .cif               (cif.unit)
  );

  assign avs_readdata    = r_reg.rdata;
  assign avs_waitrequest = r_reg.waitreq;
  assign cap_irq         = r_reg.cap_irq;
  assign ovf_irq         = r_reg.ovf_irq;
  assign count_top       = r_reg.top;
  assign count_bottom    = r_reg.bottom;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_STOP_HOLD: assert property ((r_reg.ctrl_b[2:0] == 3'h0 && !(wr && avs_address == OFS_CNT_LO))
    |=> $stable(r_reg.count))
    else $error("count moved with no tick source");
  AST_CPU_WINS: assert property ((wr && avs_address == OFS_CNT_LO)
    |=> r_reg.count == {$past(r_reg.temp), $past(wd)})
    else $error("software count write lost");
  AST_CAP_COPY: assert property (cif.capture |=> r_reg.capture == $past(r_reg.count) && r_reg.cap_flag)
    else $error("capture copy or flag wrong");
  AST_BOTTOM: assert property (count_bottom == (r_reg.count == BOTTOM))
    else $error("bottom indication wrong");
  AST_LATCH_LOAD: assert property ((rd && avs_address == OFS_CAP_LO) |=> r_reg.temp == $past(r_reg.rd_hi))
    else $error("latch not loaded on lower read");
  AST_ICR_LOCK: assert property ((wr && avs_address == OFS_CAP_LO && !icr_top && !cif.capture)
    |=> $stable(r_reg.capture))
    else $error("capture register written in wrong mode");
  AST_OVF_SET: assert property (ovf_evt |=> r_reg.ovf_flag)
    else $error("overflow flag not set");
  AST_IRQ: assert property ((cif.capture && r_reg.cap_ie) |=> ##[0:1] cap_irq)
    else $error("capture interrupt missing");
  AST_BUS_ANS: assert property (((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");
  CV_CAPTURE: cover property (cif.capture && r_reg.cap_flag);
  CV_OVF: cover property (ovf_evt && dual);
  CV_TURN: cover property (tick && dual && r_reg.dir == DIR_UP && r_reg.count >= top_val);
  CV_ICR_WRITE: cover property (wr && avs_address == OFS_CAP_LO && icr_top);
  // step checks leave out a same-cycle software write, which overrides the tick
  AST_UP_STEP: assert property ((tick && !dual && r_reg.count < top_val)
    && !(wr && avs_address == OFS_CNT_LO) |=> r_reg.count == 16'($past(r_reg.count) + 16'h0001))
    else $error("count did not step up by one");
  AST_DOWN_STEP: assert property ((tick && dual && r_reg.dir == DIR_DOWN && r_reg.count != BOTTOM)
    && !(wr && avs_address == OFS_CNT_LO) |=> r_reg.count == 16'($past(r_reg.count) - 16'h0001))
    else $error("count did not step down by one");
  AST_PRESC_CLR: assert property (r_reg.ctrl_b[B_CLK_SEL+2:B_CLK_SEL] == 3'h0
    |=> r_reg.presc == '0)
    else $error("prescaler ran with no tick source");
  AST_CAP_CLR: assert property ((wr && avs_address == OFS_FLAGS && wd[B_CAP] && !cif.capture)
    |=> !r_reg.cap_flag)
    else $error("capture flag not cleared by write one");
  AST_ACK_CLR: assert property ((cap_irq_ack && !cif.capture)
    |=> !r_reg.cap_flag && !cap_irq)
    else $error("capture flag not cleared by service");
  AST_OVF_CLR: assert property ((ovf_irq_ack && !ovf_evt)
    |=> !r_reg.ovf_flag && !ovf_irq)
    else $error("overflow flag not cleared by service");
  // every access gets exactly one wait cycle, so the accept pulse never stretches
  AST_WAIT_ONE: assert property (!avs_waitrequest
    |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_CNT_LATCH: assert property ((avs_read && avs_waitrequest && avs_address == OFS_CNT_LO)
    |=> ##1 r_reg.temp == $past(r_reg.count[15:8], 2))
    else $error("latch not loaded from count on lower read");
endmodule : tcc_timer

// *** verif/tcc_event_src.sv ***
`timescale 1ns/1ps
// ==========================================================
// far side: external event pin and comparator output
module tcc_event_src
(
  input  wire logic sys_clk,
  output logic      capture_pin,
  output logic      comparator_output
);
  initial
  begin
    capture_pin       = 1'b0;
    comparator_output = 1'b0;
  end
  // levels change only just after a rising edge, as a clean external source would
  task automatic drive(input logic sel, input logic v);
    @(posedge sys_clk);
    if (sel)
      comparator_output <= v;
    else
      capture_pin <= v;
  endtask : drive
endmodule : tcc_event_src

// *** verif/tb_timer16_counter_input_capture.sv ***
`timescale 1ns/1ps
module tb_timer16_counter_input_capture;
  import tcc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_tick_pin = 1'b0;
  logic        cap_pin;
  logic        cmp_out;
  logic        cap_irq_ack = 1'b0;
  logic        ovf_irq_ack = 1'b0;
  logic        cap_irq;
  logic        ovf_irq;
  logic        count_top;
  logic        count_bottom;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [7:0]  rd;
  int          lat0;
  int          lat1;

  always #25 sys_clk = ~sys_clk;

  tcc_timer i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_tick_pin(ext_tick_pin),
    .capture_pin(cap_pin), .comparator_output(cmp_out), .cap_irq_ack(cap_irq_ack),
    .ovf_irq_ack(ovf_irq_ack), .cap_irq(cap_irq), .ovf_irq(ovf_irq), .count_top(count_top),
    .count_bottom(count_bottom));

  tcc_event_src i_src (.sys_clk(sys_clk), .capture_pin(cap_pin), .comparator_output(cmp_out));

  // ==========================================================
  // checking and closing
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // the whole run needs under a thousand cycles; a hung handshake lands here
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // ==========================================================
  // register bus: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    bus(1'b0, lo, 8'h00, l);
    bus(1'b0, lo + 4'h1, 8'h00, h);
    v = {h, l};
  endtask : rd16

  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16

  // settle the source low, clear the capture flag, raise it, count edges to cap_irq
  task automatic fire(input logic sel, output int lat);
    i_src.drive(sel, 1'b0);
    repeat (14) @(posedge sys_clk);
    wr(OFS_FLAGS, 8'h20);
    i_src.drive(sel, 1'b1);
    lat = 0;
    while (cap_irq !== 1'b1 && lat < 40)
    begin
      @(posedge sys_clk);
      lat++;
    end
  endtask : fire

  // ==========================================================
  // scenarios
  task automatic t_reset_and_count_access();
    logic [15:0] v;
    check("bottom at reset", count_bottom, 1'b1);
    rd16(OFS_CNT_LO, v);
    check("count reset", v, RST_WORD);
    wr16(OFS_CNT_LO, 16'h01ff);
    rd16(OFS_CNT_LO, v);
    check("count rw stopped", v, 16'h01ff);
    repeat (20) @(posedge sys_clk);
    rd16(OFS_CNT_LO, v);
    check("count holds without tick", v, 16'h01ff);
    check("bottom clear", count_bottom, 1'b0);
    check("top clear", count_top, 1'b0);
    wr(OFS_CMPA_HI, 8'h12);
    wr(OFS_CMPA_LO, 8'h34);
    wr(OFS_CNT_LO, 8'h56);
    rd16(OFS_CNT_LO, v);
    check("shared latch reused for count", v, 16'h1256);
    rd16(OFS_CMPA_LO, v);
    check("shared latch reused for compare", v, 16'h1234);
    wr(OFS_CTRL_B, 8'h07);
    repeat (3)
    begin
      @(posedge sys_clk);
      ext_tick_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_tick_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    wr(OFS_CTRL_B, 8'h00);
    rd16(OFS_CNT_LO, v);
    check("external tick edges", v, 16'h1259);
    bus(1'b0, 4'hb, 8'h00, rd);
    check("unmapped read", rd, 8'h00);
  endtask : t_reset_and_count_access

  task automatic t_overflow();
    logic [15:0] v;
    wr(OFS_INT_EN, 8'h01);
    wr16(OFS_CNT_LO, 16'hfffe);
    wr(OFS_CTRL_B, 8'h01);
    repeat (6) @(posedge sys_clk);
    wr(OFS_CTRL_B, 8'h00);
    check("overflow irq", ovf_irq, 1'b1);
    rd16(OFS_CNT_LO, v);
    check("count ran past wrap", v < 16'h0010, 1'b1);
    wr(OFS_FLAGS, 8'h01);
    bus(1'b0, OFS_FLAGS, 8'h00, rd);
    check("overflow cleared", rd[B_OVF], 1'b0);
  endtask : t_overflow

  task automatic t_capture_value();
    logic [15:0] v;
    int          l;
    wr(OFS_INT_EN, 8'h20);
    wr(OFS_CTRL_B, 8'h40);
    wr16(OFS_CNT_LO, 16'h5a3c);
    fire(1'b0, l);
    bus(1'b0, OFS_FLAGS, 8'h00, rd);
    check("capture flag", rd[B_CAP], 1'b1);
    rd16(OFS_CAP_LO, v);
    check("capture value", v, 16'h5a3c);
    wr16(OFS_CNT_LO, 16'h1111);
    fire(1'b0, l);
    rd16(OFS_CAP_LO, v);
    check("capture overwrite", v, 16'h1111);
    @(posedge sys_clk);
    cap_irq_ack <= 1'b1;
    @(posedge sys_clk);
    cap_irq_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("irq after ack", cap_irq, 1'b0);
  endtask : t_capture_value

  task automatic t_filter();
    int l;
    wr(OFS_CTRL_B, 8'h40);
    fire(1'b0, lat0);
    wr(OFS_CTRL_B, 8'hc0);
    fire(1'b0, lat1);
    check("filter adds four", lat1 - lat0, 16'd4);
    i_src.drive(1'b0, 1'b0);
    repeat (14) @(posedge sys_clk);
    wr(OFS_FLAGS, 8'h20);
    i_src.drive(1'b0, 1'b1);
    repeat (2) i_src.drive(1'b0, 1'b1);
    i_src.drive(1'b0, 1'b0);
    repeat (16) @(posedge sys_clk);
    check("glitch filtered", cap_irq, 1'b0);
  endtask : t_filter

  task automatic t_comparator_source();
    logic [15:0] v;
    int          l;
    wr(OFS_CTRL_B, 8'h40);
    wr(OFS_CMP_CS, 8'h04);
    wr16(OFS_CNT_LO, 16'h0abc);
    fire(1'b1, l);
    check("comparator capture", cap_irq, 1'b1);
    rd16(OFS_CAP_LO, v);
    check("comparator value", v, 16'h0abc);
    wr(OFS_CMP_CS, 8'h00);
  endtask : t_comparator_source

  task automatic t_capture_as_top();
    logic [15:0] v;
    int          l;
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CTRL_B, 8'h58);
    fire(1'b0, l);
    check("no capture in top mode", cap_irq, 1'b0);
    wr16(OFS_CAP_LO, 16'h7788);
    rd16(OFS_CAP_LO, v);
    check("capture written", v, 16'h7788);
    wr(OFS_CTRL_B, 8'h40);
    wr16(OFS_CAP_LO, 16'h1234);
    rd16(OFS_CAP_LO, v);
    check("capture locked outside top modes", v, 16'h7788);
  endtask : t_capture_as_top

  // dual slope 8-bit: turn at the fixed top, overflow at the bottom turn
  task automatic t_dual_slope();
    logic [15:0] v;
    wr(OFS_CTRL_A, 8'h01);
    wr16(OFS_CNT_LO, 16'h00ff);
    @(posedge sys_clk);
    check("top at fixed 8-bit top", count_top, 1'b1);
    wr(OFS_CTRL_B, 8'h41);
    repeat (20) @(posedge sys_clk);
    wr(OFS_CTRL_B, 8'h40);
    rd16(OFS_CNT_LO, v);
    check("dual turns down at top", v > 16'h00c0 && v < 16'h00ff, 1'b1);
    wr(OFS_FLAGS, 8'h01);
    wr16(OFS_CNT_LO, 16'h0003);
    wr(OFS_CTRL_B, 8'h41);
    repeat (20) @(posedge sys_clk);
    wr(OFS_CTRL_B, 8'h40);
    rd16(OFS_CNT_LO, v);
    check("dual turns up at bottom", v > 16'h0000 && v < 16'h0040, 1'b1);
    wr(OFS_INT_EN, 8'h01);
    @(posedge sys_clk);
    check("dual overflow irq", ovf_irq, 1'b1);
    ovf_irq_ack <= 1'b1;
    @(posedge sys_clk);
    ovf_irq_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("overflow ack clears", ovf_irq, 1'b0);
  endtask : t_dual_slope

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_and_count_access();
    t_overflow();
    t_capture_value();
    t_filter();
    t_comparator_source();
    t_capture_as_top();
    t_dual_slope();
    conclude();
  end
endmodule : tb_timer16_counter_input_capture
